/* core/imau_core.sv */
// imau core: multiply and multiply-accumulate datapath with status register
`timescale 1ns/100ps
`default_nettype none

module imau_core (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire imau_pkg::imau_req_t i_req,
  input wire logic [imau_pkg::ADDR_W-1:0] i_addr,
  input wire logic [imau_pkg::WORD_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [imau_pkg::WORD_W-1:0] o_rdata,
  output imau_pkg::imau_wb_t o_wb,
  output imau_pkg::imau_flags_t o_flags
);

  // sign-extend a halfword to the multiplier operand width
  function automatic logic [imau_pkg::EXT_W-1:0] sext_half(
    input logic [imau_pkg::HALF_W-1:0] h
  );
    sext_half = {{(imau_pkg::EXT_W-imau_pkg::HALF_W){h[imau_pkg::HALF_W-1]}}, h};
  endfunction : sext_half

  // pick the top or bottom halfword of a word
  function automatic logic [imau_pkg::HALF_W-1:0] pick_half(
    input logic [imau_pkg::WORD_W-1:0] w,
    input logic top
  );
    if (top) begin
      pick_half = w[imau_pkg::WORD_W-1:imau_pkg::HALF_W];
    end else begin
      pick_half = w[imau_pkg::HALF_W-1:0];
    end
  endfunction : pick_half

  // signed overflow of a 32-bit addition
  function automatic logic add_ovf(
    input logic [imau_pkg::WORD_W-1:0] x,
    input logic [imau_pkg::WORD_W-1:0] y,
    input logic [imau_pkg::WORD_W-1:0] s
  );
    add_ovf = (x[imau_pkg::WORD_W-1] == y[imau_pkg::WORD_W-1]) &&
              (s[imau_pkg::WORD_W-1] != x[imau_pkg::WORD_W-1]);
  endfunction : add_ovf

  // stage 0: operand preparation
  logic [imau_pkg::EXT_W-1:0] mul_a;
  logic [imau_pkg::EXT_W-1:0] mul_b;
  logic [imau_pkg::IDX_W-1:0] dest_sel;
  logic [imau_pkg::WIDE_W-1:0] prod;

  always_comb begin
    mul_a = {1'b0, i_req.first_val};
    mul_b = {1'b0, i_req.second_val};
    case (i_req.op)
      imau_pkg::PRODUCT_LOW_WORD_OP,
      imau_pkg::PRODUCT_PLUS_ADDEND_OP,
      imau_pkg::ADDEND_MINUS_PRODUCT_OP: begin
        // low word is the same for either signedness, so zero-extend
        mul_a = {1'b0, i_req.first_val};
        mul_b = {1'b0, i_req.second_val};
      end
      imau_pkg::UNSIGNED_WIDE_PRODUCT_OP,
      imau_pkg::UNSIGNED_WIDE_DOUBLE_ADD_OP,
      imau_pkg::UNSIGNED_WIDE_ACCUMULATE_OP: begin
        mul_a = {1'b0, i_req.first_val};
        mul_b = {1'b0, i_req.second_val};
      end
      imau_pkg::SIGNED_HALF_LOW_SEL_ACC_OP: begin
        mul_a = sext_half(pick_half(i_req.first_val, i_req.first_top));
        mul_b = sext_half(pick_half(i_req.second_val, 1'b0));
      end
      imau_pkg::SIGNED_HALF_HIGH_SEL_ACC_OP: begin
        mul_a = sext_half(pick_half(i_req.first_val, i_req.first_top));
        mul_b = sext_half(pick_half(i_req.second_val, 1'b1));
      end
      imau_pkg::SIGNED_WORD_BY_LOW_HALF_ACC_OP: begin
        mul_a = {i_req.first_val[imau_pkg::WORD_W-1], i_req.first_val};
        mul_b = sext_half(pick_half(i_req.second_val, 1'b0));
      end
      imau_pkg::SIGNED_WORD_BY_HIGH_HALF_ACC_OP: begin
        mul_a = {i_req.first_val[imau_pkg::WORD_W-1], i_req.first_val};
        mul_b = sext_half(pick_half(i_req.second_val, 1'b1));
      end
      default: begin
        mul_a = {1'b0, i_req.first_val};
        mul_b = {1'b0, i_req.second_val};
      end
    endcase
  end

  always_comb begin
    dest_sel = i_req.dest_idx;
    if (i_req.op == imau_pkg::PRODUCT_LOW_WORD_OP && i_req.dest_omitted) begin
      dest_sel = i_req.first_idx;
    end
  end

  imau_mul u_mul (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_a(mul_a),
    .i_b(mul_b),
    .o_prod(prod)
  );

  // stage 1: registers beside the product
  logic s1_valid_q;
  logic s1_pass_q;
  logic s1_setf_q;
  imau_pkg::imau_op_t s1_op_q;
  logic [imau_pkg::IDX_W-1:0] s1_dest_q;
  logic [imau_pkg::IDX_W-1:0] s1_lo_idx_q;
  logic [imau_pkg::IDX_W-1:0] s1_hi_idx_q;
  logic [imau_pkg::WORD_W-1:0] s1_addend_q;
  logic [imau_pkg::WORD_W-1:0] s1_lo_q;
  logic [imau_pkg::WORD_W-1:0] s1_hi_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      s1_valid_q <= 1'b0;
      s1_pass_q <= 1'b0;
    end else begin
      s1_valid_q <= i_req.valid;
      s1_pass_q <= i_req.valid && i_req.pred_pass;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      s1_op_q <= imau_pkg::PRODUCT_LOW_WORD_OP;
      s1_setf_q <= 1'b0;
      s1_dest_q <= '0;
      s1_lo_idx_q <= '0;
      s1_hi_idx_q <= '0;
    end else begin
      s1_op_q <= i_req.op;
      s1_setf_q <= i_req.set_flags;
      s1_dest_q <= dest_sel;
      s1_lo_idx_q <= i_req.lo_idx;
      s1_hi_idx_q <= i_req.hi_idx;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      s1_addend_q <= '0;
      s1_lo_q <= '0;
      s1_hi_q <= '0;
    end else begin
      s1_addend_q <= i_req.addend_val;
      s1_lo_q <= i_req.lo_val;
      s1_hi_q <= i_req.hi_val;
    end
  end

  // stage 2: result forming
  logic [imau_pkg::WORD_W-1:0] res_lo;
  logic [imau_pkg::WORD_W-1:0] res_hi;
  logic [imau_pkg::WIDE_W-1:0] wide;
  logic [imau_pkg::WORD_W-1:0] prod_lo;
  logic [imau_pkg::WORD_W-1:0] prod_wh;
  logic is_wide;
  logic nz_upd;
  logic q_hit;

  assign prod_lo = prod[imau_pkg::WORD_W-1:0];
  assign prod_wh = prod[imau_pkg::WH_MSB:imau_pkg::WH_LSB];

  always_comb begin
    wide = prod;
    res_lo = prod_lo;
    is_wide = 1'b0;
    nz_upd = 1'b0;
    q_hit = 1'b0;
    case (s1_op_q)
      imau_pkg::PRODUCT_LOW_WORD_OP: begin
        res_lo = prod_lo;
        nz_upd = s1_setf_q;
      end
      imau_pkg::PRODUCT_PLUS_ADDEND_OP: begin
        res_lo = prod_lo + s1_addend_q;
        nz_upd = 1'b1;
      end
      imau_pkg::ADDEND_MINUS_PRODUCT_OP: begin
        res_lo = s1_addend_q - prod_lo;
        nz_upd = 1'b0;
      end
      imau_pkg::UNSIGNED_WIDE_PRODUCT_OP: begin
        wide = prod;
        is_wide = 1'b1;
      end
      imau_pkg::UNSIGNED_WIDE_DOUBLE_ADD_OP: begin
        // cannot carry out: max product plus two words fits 64 bits
        wide = prod + {{imau_pkg::WORD_W{1'b0}}, s1_hi_q}
                    + {{imau_pkg::WORD_W{1'b0}}, s1_lo_q};
        is_wide = 1'b1;
      end
      imau_pkg::UNSIGNED_WIDE_ACCUMULATE_OP: begin
        wide = prod + {s1_hi_q, s1_lo_q};
        is_wide = 1'b1;
      end
      imau_pkg::SIGNED_HALF_LOW_SEL_ACC_OP,
      imau_pkg::SIGNED_HALF_HIGH_SEL_ACC_OP: begin
        res_lo = prod_lo + s1_addend_q;
        q_hit = add_ovf(prod_lo, s1_addend_q, res_lo);
      end
      imau_pkg::SIGNED_WORD_BY_LOW_HALF_ACC_OP,
      imau_pkg::SIGNED_WORD_BY_HIGH_HALF_ACC_OP: begin
        res_lo = prod_wh + s1_addend_q;
        q_hit = add_ovf(prod_wh, s1_addend_q, res_lo);
      end
      default: begin
        res_lo = prod_lo;
      end
    endcase
    if (is_wide) begin
      res_lo = wide[imau_pkg::WORD_W-1:0];
    end
    res_hi = wide[imau_pkg::WIDE_W-1:imau_pkg::WORD_W];
  end

  // write-back port
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_wb <= '0;
    end else begin
      o_wb.valid <= s1_valid_q;
      o_wb.wr_en <= s1_pass_q;
      o_wb.wr2_en <= s1_pass_q && is_wide;
      // distinct pair is the issuer's duty; both ports fire as named
      o_wb.wr_idx <= is_wide ? s1_lo_idx_q : s1_dest_q;
      o_wb.wr2_idx <= s1_hi_idx_q;
      o_wb.wr_data <= res_lo;
      o_wb.wr2_data <= res_hi;
    end
  end

  // status flags
  logic sw_status_wr;
  logic upd_nz;
  logic set_q;

  assign sw_status_wr = i_wr && (i_addr == imau_pkg::STATUS_OFS);
  // wide forms never set nz_upd or q_hit, so their flags stay put
  assign upd_nz = s1_pass_q && nz_upd;
  assign set_q = s1_pass_q && q_hit;

  // hardware update wins over a software write in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_flags.n <= imau_pkg::FLAG_RST;
      o_flags.z <= imau_pkg::FLAG_RST;
    end else if (upd_nz) begin
      o_flags.n <= res_lo[imau_pkg::WORD_W-1];
      o_flags.z <= (res_lo == '0);
    end else if (sw_status_wr) begin
      o_flags.n <= i_wdata[imau_pkg::FLAG_N];
      o_flags.z <= i_wdata[imau_pkg::FLAG_Z];
    end
  end

  // carry and overflow belong to other units; only software moves them
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_flags.c <= imau_pkg::FLAG_RST;
      o_flags.v <= imau_pkg::FLAG_RST;
    end else if (sw_status_wr) begin
      o_flags.c <= i_wdata[imau_pkg::FLAG_C];
      o_flags.v <= i_wdata[imau_pkg::FLAG_V];
    end
  end

  // sticky: only a software write of zero clears it, and a set wins
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_flags.q <= imau_pkg::FLAG_RST;
    end else if (set_q) begin
      o_flags.q <= 1'b1;
    end else if (sw_status_wr) begin
      o_flags.q <= i_wdata[imau_pkg::FLAG_Q];
    end
  end

  // activity registers
  logic [imau_pkg::CNT_W-1:0] opcnt_q;
  logic [imau_pkg::WORD_W-1:0] lastop_q;

  // counts retired operations whose predicate passed; wraps silently
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      opcnt_q <= '0;
    end else if (i_wr && i_addr == imau_pkg::OPCNT_OFS) begin
      opcnt_q <= i_wdata;
    end else if (s1_pass_q) begin
      opcnt_q <= opcnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      lastop_q <= '0;
    end else if (s1_valid_q) begin
      lastop_q <= '0;
      lastop_q[imau_pkg::LAST_OP_LSB +: 4] <= s1_op_q;
      lastop_q[imau_pkg::LAST_PASS] <= s1_pass_q;
    end
  end

  // register read port
  logic [imau_pkg::WORD_W-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[imau_pkg::FLAG_N] = o_flags.n;
    status_word[imau_pkg::FLAG_Z] = o_flags.z;
    status_word[imau_pkg::FLAG_C] = o_flags.c;
    status_word[imau_pkg::FLAG_V] = o_flags.v;
    status_word[imau_pkg::FLAG_Q] = o_flags.q;
  end

  // data stand only in the cycle after the strobe; zero otherwise
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (!i_rd) begin
      o_rdata <= '0;
    end else if (i_addr == imau_pkg::STATUS_OFS) begin
      o_rdata <= status_word;
    end else if (i_addr == imau_pkg::OPCNT_OFS) begin
      o_rdata <= opcnt_q;
    end else if (i_addr == imau_pkg::LASTOP_OFS) begin
      o_rdata <= lastop_q;
    end else begin
      o_rdata <= '0;
    end
  end

endmodule : imau_core

`default_nettype wire

/* core/imau_mul.sv */
// imau multiplier: registered 33x33 signed product
`timescale 1ns/100ps
`default_nettype none

module imau_mul (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [imau_pkg::EXT_W-1:0] i_a,
  input wire logic [imau_pkg::EXT_W-1:0] i_b,
  output logic [imau_pkg::WIDE_W-1:0] o_prod
);

  // one signed array serves both zero- and sign-extended operands
  logic signed [imau_pkg::PROD_W-1:0] full;

  assign full = $signed(i_a) * $signed(i_b);

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_prod <= '0;
    end else begin
      o_prod <= full[imau_pkg::WIDE_W-1:0];
    end
  end

endmodule : imau_mul

`default_nettype wire

/* include/imau_pkg.sv */
// imau package: widths, operation codes, carriers and status map
// Behaviour
// - plain multiply writes only the low 32 product bits to the destination.
// - multiply-add adds the addend to the product, low 32 bits written.
// - multiply-subtract takes the product from the addend, low 32 bits written.
// - short multiplies give identical bits signed or unsigned; one low-word path.
// - plain multiply without a destination writes into the first operand register.
// - multiply-add and flag-setting multiply update N and Z, keep C and V.
// - unsigned wide multiply writes low word and high word of the 64-bit product.
// - double-add wide multiply adds old high and old low words to the product.
// - accumulating wide multiply adds the old 64-bit pair to the product.
// - wide multiplies leave every condition flag unchanged.
// - low-select halfword forms take second operand bits 15:0 as signed multiplier.
// - high-select halfword forms take second operand bits 31:16 as signed multiplier.
// - halfword-by-halfword forms add the addend to the 32-bit signed product.
// - word-by-halfword forms add the addend to the top 32 of 48 product bits.
// - addend overflow in word-by-halfword forms sets the sticky saturation flag.
`default_nettype none
package imau_pkg;

  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned WIDE_W = 64;
  localparam int unsigned EXT_W = 33;
  localparam int unsigned PROD_W = 66;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W = 32;

  // word-by-halfword product: 48 bits, the lowest 16 are dropped
  localparam int unsigned WH_LSB = 16;
  localparam int unsigned WH_MSB = 47;

  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] OPCNT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] LASTOP_OFS = 8'h08;

  // status word layout
  localparam int unsigned FLAG_N = 31;
  localparam int unsigned FLAG_Z = 30;
  localparam int unsigned FLAG_C = 29;
  localparam int unsigned FLAG_V = 28;
  localparam int unsigned FLAG_Q = 27;
  localparam logic FLAG_RST = 1'b0;

  // last-op word layout
  localparam int unsigned LAST_PASS = 8;
  localparam int unsigned LAST_OP_LSB = 0;

  typedef enum logic [3:0] {
    PRODUCT_LOW_WORD_OP,
    PRODUCT_PLUS_ADDEND_OP,
    ADDEND_MINUS_PRODUCT_OP,
    UNSIGNED_WIDE_PRODUCT_OP,
    UNSIGNED_WIDE_DOUBLE_ADD_OP,
    UNSIGNED_WIDE_ACCUMULATE_OP,
    SIGNED_HALF_LOW_SEL_ACC_OP,
    SIGNED_HALF_HIGH_SEL_ACC_OP,
    SIGNED_WORD_BY_LOW_HALF_ACC_OP,
    SIGNED_WORD_BY_HIGH_HALF_ACC_OP
  } imau_op_t;

  typedef struct packed {
    logic valid;
    imau_op_t op;
    logic set_flags;
    logic pred_pass;
    logic dest_omitted;
    logic first_top;
    logic [IDX_W-1:0] dest_idx;
    logic [IDX_W-1:0] first_idx;
    logic [IDX_W-1:0] lo_idx;
    logic [IDX_W-1:0] hi_idx;
    logic [WORD_W-1:0] first_val;
    logic [WORD_W-1:0] second_val;
    logic [WORD_W-1:0] addend_val;
    logic [WORD_W-1:0] lo_val;
    logic [WORD_W-1:0] hi_val;
  } imau_req_t;

  typedef struct packed {
    logic valid;
    logic wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [WORD_W-1:0] wr_data;
    logic wr2_en;
    logic [IDX_W-1:0] wr2_idx;
    logic [WORD_W-1:0] wr2_data;
  } imau_wb_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
    logic q;
  } imau_flags_t;

endpackage : imau_pkg

`default_nettype wire

/* testbench/imau_chk.sv */
// imau checker: result timing, values and flag behaviour at the core ports
`timescale 1ns/100ps
`default_nettype none

module imau_chk (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire imau_pkg::imau_req_t i_req,
  input wire logic [imau_pkg::ADDR_W-1:0] i_addr,
  input wire logic [imau_pkg::WORD_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [imau_pkg::WORD_W-1:0] o_rdata,
  input wire imau_pkg::imau_wb_t o_wb,
  input wire imau_pkg::imau_flags_t o_flags
);
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  logic go;
  logic wide;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] c;
  assign go = i_req.valid && i_req.pred_pass;
  assign wide = i_req.op inside {[imau_pkg::UNSIGNED_WIDE_PRODUCT_OP :
    imau_pkg::UNSIGNED_WIDE_ACCUMULATE_OP]};
  assign a = i_req.first_val;
  assign b = i_req.second_val;
  assign c = i_req.addend_val;

  AST_RETIRE: assert property (i_req.valid |-> ##2 o_wb.valid)
    else $error("no write-back two cycles after a request");
  AST_PRED_FAIL: assert property (i_req.valid && !i_req.pred_pass |-> ##2
    !o_wb.wr_en && !o_wb.wr2_en && $stable(o_flags))
    else $error("failed predicate wrote a register or a flag");
  AST_MUL_LOW: assert property (go && i_req.op == imau_pkg::PRODUCT_LOW_WORD_OP |-> ##2
    o_wb.wr_data == 32'($past(a, 2) * $past(b, 2)))
    else $error("plain multiply low word wrong");
  AST_DEST_OMIT: assert property (go && i_req.dest_omitted &&
    i_req.op == imau_pkg::PRODUCT_LOW_WORD_OP |-> ##2 o_wb.wr_idx == $past(i_req.first_idx, 2))
    else $error("omitted destination not the first operand");
  AST_PLUS: assert property (go && i_req.op == imau_pkg::PRODUCT_PLUS_ADDEND_OP |-> ##2
    o_wb.wr_data == 32'($past(a, 2) * $past(b, 2) + $past(c, 2)) &&
    o_flags.n == o_wb.wr_data[31] && $stable(o_flags.c) && $stable(o_flags.v))
    else $error("multiply-add result or flags wrong");
  AST_MINUS: assert property (go && i_req.op == imau_pkg::ADDEND_MINUS_PRODUCT_OP |-> ##2
    o_wb.wr_data == 32'($past(c, 2) - $past(a, 2) * $past(b, 2)) && $stable(o_flags))
    else $error("multiply-subtract result or flags wrong");
  AST_WIDE_PAIR: assert property (go && wide |-> ##2 o_wb.wr_en && o_wb.wr2_en &&
    o_wb.wr_idx == $past(i_req.lo_idx, 2) && o_wb.wr2_idx == $past(i_req.hi_idx, 2) &&
    $stable(o_flags))
    else $error("wide op pairing or flags wrong");
  AST_UNSIGNED_WIDE_PRODUCT_OP: assert property (go && i_req.op == imau_pkg::UNSIGNED_WIDE_PRODUCT_OP |-> ##2
    {o_wb.wr2_data, o_wb.wr_data} == 64'($past(a, 2)) * 64'($past(b, 2)))
    else $error("unsigned wide product wrong");
  AST_Q_HOLD: assert property (o_flags.q && !(i_wr && i_addr == imau_pkg::STATUS_OFS)
    |=> o_flags.q)
    else $error("sticky saturation flag dropped");

  cover property (go && wide);
  cover property ($rose(o_flags.q));
  cover property (i_req.valid && !i_req.pred_pass);
endmodule : imau_chk

bind imau_core imau_chk u_chk (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_req(i_req),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_wb(o_wb), .o_flags(o_flags));

`default_nettype wire

/* testbench/imau_rf_model.sv */
// imau register file model: takes the core's write-backs
`timescale 1ns/100ps
`default_nettype none

module imau_rf_model (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire imau_pkg::imau_wb_t i_wb
);
  logic [imau_pkg::WORD_W-1:0] regs [16];

  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      for (int i = 0; i < 16; i++) regs[i] <= '0;
    end else if (i_wb.valid) begin
      if (i_wb.wr_en) regs[i_wb.wr_idx] <= i_wb.wr_data;
      // pair indices differ, so both halves land
      if (i_wb.wr2_en) regs[i_wb.wr2_idx] <= i_wb.wr2_data;
    end
  end
endmodule : imau_rf_model

`default_nettype wire

/* testbench/testbench.sv */
// imau testbench: random and directed operations, register accesses, result checks
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  imau_pkg::imau_req_t req = '0;
  logic [imau_pkg::ADDR_W-1:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_p = 1'b0;
  logic [31:0] rdata;
  logic [31:0] ew;
  imau_pkg::imau_wb_t wb;
  imau_pkg::imau_flags_t flags;
  imau_pkg::imau_wb_t e;
  imau_pkg::imau_flags_t f;
  imau_pkg::imau_flags_t ef = '0;
  imau_pkg::imau_wb_t wq[$];
  imau_pkg::imau_flags_t fq[$];
  logic [31:0] rq[$];
  logic [31:0] seed = 32'h4e;
  logic [31:0] cnt = 32'h0;
  logic [31:0] last = 32'h0;
  int fail_count = 0;
  int checks_done = 0;

  always #50 i_clk_sys = ~i_clk_sys;

  imau_core dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_req(req), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_wb(wb), .o_flags(flags));
  imau_rf_model pm (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wb(wb));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task automatic cmp_word(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : cmp_word

  task automatic cmp_bits(input string nm, input logic [4:0] x, input logic [4:0] g);
    checks_done++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", nm, x, g);
    end
  endtask : cmp_bits

  task automatic op(input imau_pkg::imau_op_t o, input logic [31:0] a, b, c, input logic p);
    imau_pkg::imau_req_t r;
    imau_pkg::imau_wb_t w;
    logic [31:0] k;
    logic [63:0] s;
    logic [15:0] ha;
    logic [15:0] hb;
    logic signed [31:0] hp;
    logic signed [47:0] wp;
    logic [31:0] x;
    logic [31:0] d;
    k = rnd();
    // low eight registers only, pair indices differ in their low three bits
    r = {1'b1, o, k[0] & p, p, k[1], k[2], 1'b0, k[6:4], 1'b0, k[10:8], 1'b0, k[14:12],
      1'b0, ~k[14:12], a, b, c, pm.regs[{1'b0, k[14:12]}], pm.regs[{1'b0, ~k[14:12]}]};
    s = 64'(a) * 64'(b);
    ha = k[2] ? a[31:16] : a[15:0];
    hb = (o == imau_pkg::SIGNED_HALF_HIGH_SEL_ACC_OP ||
      o == imau_pkg::SIGNED_WORD_BY_HIGH_HALF_ACC_OP) ? b[31:16] : b[15:0];
    hp = $signed(ha) * $signed(hb);
    wp = $signed(a) * $signed(hb);
    x = (o < imau_pkg::SIGNED_WORD_BY_LOW_HALF_ACC_OP) ? hp : wp[47:16];
    d = x + c;
    w = '0;
    w.valid = 1'b1;
    w.wr_en = p;
    w.wr_idx = (k[1] && o == imau_pkg::PRODUCT_LOW_WORD_OP) ? r.first_idx : r.dest_idx;
    case (o)
      imau_pkg::PRODUCT_LOW_WORD_OP: d = s[31:0];
      imau_pkg::PRODUCT_PLUS_ADDEND_OP: d = s[31:0] + c;
      imau_pkg::ADDEND_MINUS_PRODUCT_OP: d = c - s[31:0];
      imau_pkg::UNSIGNED_WIDE_DOUBLE_ADD_OP: s = s + r.hi_val + r.lo_val;
      imau_pkg::UNSIGNED_WIDE_ACCUMULATE_OP: s = s + {r.hi_val, r.lo_val};
      default: ;
    endcase
    if (o inside {[imau_pkg::UNSIGNED_WIDE_PRODUCT_OP : imau_pkg::UNSIGNED_WIDE_ACCUMULATE_OP]}) begin
      w.wr_idx = r.lo_idx;
      w.wr2_en = p;
      w.wr2_idx = r.hi_idx;
      w.wr2_data = s[63:32];
      d = s[31:0];
    end
    w.wr_data = d;
    if (p) begin
      cnt++;
      if (o == imau_pkg::PRODUCT_PLUS_ADDEND_OP || (o == imau_pkg::PRODUCT_LOW_WORD_OP && r.set_flags))
        {ef.n, ef.z} = {d[31], d == 32'h0};
      if (o >= imau_pkg::SIGNED_HALF_LOW_SEL_ACC_OP)
        ef.q |= (x[31] == c[31]) && (d[31] != x[31]);
    end
    last = {23'h0, p, 4'h0, 4'(o)};
    wq.push_back(w);
    fq.push_back(ef);
    @(posedge i_clk_sys);
    req <= r;
  endtask : op

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk_sys);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back(x);
    @(posedge i_clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk_sys);
    rd <= 1'b0;
  endtask : reg_rd

  // bounded wait for every queued result to come back
  task automatic drain(input string nm);
    @(posedge i_clk_sys);
    req <= '0;
    for (int i = 0; i < 8 && wq.size() != 0; i++) @(posedge i_clk_sys);
    cmp_bits("pending results", 5'h0, 5'(wq.size()));
    if (wq.size() != 0) complete_run();
    $display("test %s done", nm);
  endtask : drain

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  always @(posedge i_clk_sys) rd_p <= rd;

  always @(negedge i_clk_sys) begin
    if (rd_p) begin
      ew = rq.pop_front();
      cmp_word("read data", ew, rdata);
    end
    if (wb.valid === 1'b1 && wq.size() == 0) cmp_bits("unexpected result", 5'h0, 5'h1);
    else if (wb.valid === 1'b1) begin
      e = wq.pop_front();
      f = fq.pop_front();
      cmp_bits("write enables", 5'({e.wr_en, e.wr2_en}), 5'({wb.wr_en, wb.wr2_en}));
      if (e.wr_en) cmp_bits("dest index", 5'(e.wr_idx), 5'(wb.wr_idx));
      if (e.wr_en) cmp_word("dest data", e.wr_data, wb.wr_data);
      if (e.wr2_en) cmp_bits("high index", 5'(e.wr2_idx), 5'(wb.wr2_idx));
      if (e.wr2_en) cmp_word("high data", e.wr2_data, wb.wr2_data);
      cmp_bits("flags", 5'(f), 5'(flags));
    end
  end

  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    reg_wr(imau_pkg::OPCNT_OFS, 32'h5);
    cnt = 32'h5;
    for (int i = 0; i < 40; i++) op(imau_pkg::imau_op_t'(i % 10), rnd(), rnd(), rnd(), i < 30);
    drain("random ops");
    // saturating add overflow, then zero and negative results
    op(imau_pkg::SIGNED_HALF_LOW_SEL_ACC_OP, 32'h7fff_7fff, 32'h0000_7fff, 32'h7fff_ffff, 1'b1);
    op(imau_pkg::PRODUCT_PLUS_ADDEND_OP, 32'h0, rnd(), 32'h0, 1'b1);
    op(imau_pkg::PRODUCT_PLUS_ADDEND_OP, 32'h0, rnd(), 32'h8000_0000, 1'b1);
    drain("flags");
    reg_wr(imau_pkg::STATUS_OFS, 32'h8000_0000);
    ef = '0;
    ef.n = 1'b1;
    reg_rd(imau_pkg::STATUS_OFS, 32'h8000_0000);
    op(imau_pkg::SIGNED_WORD_BY_LOW_HALF_ACC_OP, 32'h7fff_ffff, 32'h0000_7fff, 32'h7fff_ffff, 1'b1);
    op(imau_pkg::UNSIGNED_WIDE_ACCUMULATE_OP, rnd(), rnd(), rnd(), 1'b1);
    op(imau_pkg::ADDEND_MINUS_PRODUCT_OP, rnd(), rnd(), rnd(), 1'b0);
    drain("status and overflow");
    reg_rd(imau_pkg::LASTOP_OFS, last);
    reg_rd(imau_pkg::OPCNT_OFS, cnt);
    reg_rd(8'h0c, 32'h0);
    drain("registers");
    complete_run();
  end
endmodule : testbench

`default_nettype wire
